// ### verilog/sptx_pkg.sv
package sptx_pkg;

  // field positions in tx_control_reg
  localparam int CTL_MODE_BIT   = 0;
  localparam int CTL_LEN_BIT    = 1;
  localparam int CTL_STOP_BIT   = 3;
  localparam int CTL_SLAVE_BIT  = 3;
  localparam int CTL_PEN_BIT    = 4;
  localparam int CTL_ODD_BIT    = 5;
  localparam int CTL_BEIE_BIT   = 6;
  localparam int CTL_DONEIE_BIT = 7;

  localparam int CTL_W  = 8;
  localparam int DATA_W = 8;

  // baud clock division per mode
  localparam logic [3:0] UART_DIV_LAST = 4'hF;
  localparam logic [3:0] SYNC_DIV_LAST = 4'h3;
  localparam logic [3:0] DIV_ZERO      = 4'h0;
  localparam logic [3:0] DIV_ONE       = 4'h1;
  localparam logic [1:0] SYNC_CLK_HIGH = 2'h2;

  // frame layout and bit counts
  localparam int          FRAME_W    = 12;
  localparam logic [3:0]  LEN_EIGHT  = 4'h8;
  localparam logic [3:0]  LEN_SEVEN  = 4'h7;
  localparam logic [3:0]  CNT_ZERO   = 4'h0;
  localparam logic [3:0]  CNT_ONE    = 4'h1;
  localparam logic [11:0] FRAME_IDLE = 12'hFFF;

  // slave inter-frame gap, CPU clocks
  localparam logic [1:0] SLAVE_GAP_LAST = 2'h1;
  localparam logic [1:0] GAP_ZERO       = 2'h0;

  // assertion bounds, baud clocks
  localparam logic [4:0] UART_WAIT_MAX = 5'h10;
  localparam logic [4:0] SYNC_WAIT_MAX = 5'h04;

  typedef enum logic [1:0] {S_IDLE, S_LOADED, S_SHIFT, S_GAP} sptx_state_t;

endpackage

// ### verilog/sptx_buffer.sv
`timescale 1ns/1ns
module sptx_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : AW'(wr_ptr + 1'b1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : AW'(rd_ptr + 1'b1);
      end
      if (push && !pop) begin
        count <= (AW+1)'(count + 1'b1);
      end else if (pop && !push) begin
        count <= (AW+1)'(count - 1'b1);
      end
    end
  end

endmodule

// ### verilog/sptx_transmitter.sv
// How it works
// - UART shift clock is baud clock divided sixteen
// - external UART baud clock feeds the divider
// - buffer write strobe starts every transmission
// - load one clock later; empty event on strobe
// - UART start bit, data LSB, parity, stop
// - frame end, nothing queued: done event, idle
// - UART start within sixteen baud clocks of write
// - queued byte reloads at frame end, no done
// - master shift clock is baud clock divided four
// - master clock and first bit start together
// - master data changes on falling clock edge
// - master first bit within four baud clocks
// - master back-to-back: one-bit high gap
// - slave edges of external clock detected here
// - slave data changes on external falling edges
// - slave back-to-back: two clock high gap
// - control bit zero selects UART or synchronous
// - bits three, four, five: stop, parity, odd
// - bits six, seven gate the two interrupts
`timescale 1ns/1ns
module sptx_transmitter
  import sptx_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // cpu side
  input  wire logic              buf_wr_strobe,
  input  wire logic [DATA_W-1:0] tx_rx_buffer,
  output logic                   buf_wr_ready,
  input  wire logic              instruction_start_strobe,
  input  wire logic [CTL_W-1:0]  tx_control_reg,
  input  wire logic              ext_clock_select,
  // baud sources
  input  wire logic              baud_tick,
  input  wire logic              ext_baud_clock_in,
  // serial pins
  output logic                   serial_data_out,
  input  wire logic              serial_clock_io_in,
  output logic                   serial_clock_io_out,
  output logic                   serial_clock_io_oe,
  // events and status
  output logic                   buf_empty_event,
  output logic                   tx_done_event,
  output logic                   buf_empty_irq,
  output logic                   tx_done_irq,
  output logic                   tx_busy
);

  sptx_state_t        state;
  logic [DATA_W-1:0]  buf_data;
  logic               buf_valid;
  logic               buf_pop;
  logic [3:0]         div_cnt;
  logic               ext_prev;
  logic               sclk_prev;
  logic               baud_evt;
  logic               shift_tick;
  logic               sclk_fall;
  logic               sclk_rise;
  logic               sync_mode;
  logic               slave;
  logic               master;
  logic [3:0]         div_last;
  logic [FRAME_W-1:0] shreg;
  logic [3:0]         bits_left;
  logic [1:0]         gap_cnt;
  logic               be_pend;
  logic               done_pend;
  logic [FRAME_W-1:0] next_frame;
  logic [3:0]         next_len;
  logic               frame_end;
  logic               load_now;

  assign sync_mode = tx_control_reg[CTL_MODE_BIT];
  assign slave     = sync_mode && tx_control_reg[CTL_SLAVE_BIT];
  assign master    = sync_mode && !tx_control_reg[CTL_SLAVE_BIT];

  // two-entry buffer behind the cpu write port
  // write strobe queues the byte
  sptx_buffer #(.WIDTH(DATA_W), .DEPTH(BUF_DEPTH)) u_buf (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (buf_wr_strobe),
    .in_ready  (buf_wr_ready),
    .in_data   (tx_rx_buffer),
    .out_valid (buf_valid),
    .out_ready (buf_pop),
    .out_data  (buf_data)
  );

  // external baud clock edge or timer overflow
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_prev  <= 1'b0;
      sclk_prev <= 1'b1;
    end else begin
      ext_prev  <= ext_baud_clock_in;
      sclk_prev <= serial_clock_io_in;
    end
  end

  assign baud_evt = (ext_clock_select && !sync_mode) ? (ext_baud_clock_in && !ext_prev)
                                                     : baud_tick;
  // slave clock edges sampled by the cpu clock
  assign sclk_fall = sclk_prev && !serial_clock_io_in;
  assign sclk_rise = !sclk_prev && serial_clock_io_in;

  assign div_last = sync_mode ? SYNC_DIV_LAST : UART_DIV_LAST;
  // free running, never restarted by writes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= DIV_ZERO;
    end else if (baud_evt) begin
      div_cnt <= (div_cnt >= div_last) ? DIV_ZERO : 4'(div_cnt + DIV_ONE);
    end
  end

  // slave shifts on external falling edge
  assign shift_tick = slave ? sclk_fall : (baud_evt && (div_cnt >= div_last));

  // frame image, bit zero goes out first
  // UART: start, data LSB first, parity, stop; synchronous: data only
  // stop length, parity enable, parity sense
  always_comb begin
    logic [3:0] dlen;
    logic       par;
    dlen       = tx_control_reg[CTL_LEN_BIT] ? LEN_SEVEN : LEN_EIGHT;
    par        = (^(buf_data & (tx_control_reg[CTL_LEN_BIT] ? 8'h7F : 8'hFF)))
                 ^ tx_control_reg[CTL_ODD_BIT];
    next_frame = FRAME_IDLE;
    next_len   = dlen;
    if (sync_mode) begin
      next_frame[DATA_W-1:0] = buf_data;
      if (tx_control_reg[CTL_LEN_BIT]) begin
        next_frame[DATA_W-1] = 1'b1;
      end
    end else begin
      next_frame[0]        = 1'b0;
      next_frame[DATA_W:1] = buf_data;
      if (tx_control_reg[CTL_LEN_BIT]) begin
        next_frame[DATA_W] = 1'b1;
      end
      if (tx_control_reg[CTL_PEN_BIT]) begin
        next_frame[dlen + CNT_ONE] = par;
      end
      next_len = 4'(dlen + CNT_ONE + {3'h0, tx_control_reg[CTL_PEN_BIT]} + CNT_ONE
                 + {3'h0, tx_control_reg[CTL_STOP_BIT]});
    end
  end

  // slave frame ends once the last bit has been taken
  assign frame_end = (state == S_SHIFT) && (bits_left == CNT_ZERO)
                     && (slave ? sclk_rise : shift_tick);

  // load one clock after the byte is queued
  // uart reloads straight at frame end
  assign load_now = buf_valid && ((state == S_IDLE)
                    || (frame_end && !sync_mode)
                    || ((state == S_GAP) && master && shift_tick)
                    || ((state == S_GAP) && slave && (gap_cnt == SLAVE_GAP_LAST)));
  assign buf_pop  = load_now;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= S_IDLE;
      shreg     <= FRAME_IDLE;
      bits_left <= CNT_ZERO;
      gap_cnt   <= GAP_ZERO;
    end else begin
      case (state)
        S_IDLE: begin
          if (load_now) begin
            state     <= S_LOADED;
            shreg     <= next_frame;
            bits_left <= next_len;
          end
        end
        // first bit and clock on first tick
        S_LOADED: begin
          if (shift_tick) begin
            state     <= S_SHIFT;
            shreg     <= {1'b1, shreg[FRAME_W-1:1]};
            bits_left <= 4'(bits_left - CNT_ONE);
          end
        end
        S_SHIFT: begin
          if (frame_end) begin
            if (load_now) begin
              state     <= S_SHIFT;
              shreg     <= {1'b1, next_frame[FRAME_W-1:1]};
              bits_left <= 4'(next_len - CNT_ONE);
            end else if (buf_valid && sync_mode) begin
              state   <= S_GAP;
              gap_cnt <= GAP_ZERO;
            end else begin
              state <= S_IDLE;
            end
          end else if (shift_tick && (bits_left != CNT_ZERO)) begin
            shreg     <= {1'b1, shreg[FRAME_W-1:1]};
            bits_left <= 4'(bits_left - CNT_ONE);
          end
        end
        S_GAP: begin
          gap_cnt <= 2'(gap_cnt + 1'b1);
          if (!buf_valid) begin
            state <= S_IDLE;
          end else if (master && shift_tick) begin
            state     <= S_SHIFT;
            shreg     <= {1'b1, next_frame[FRAME_W-1:1]};
            bits_left <= 4'(next_len - CNT_ONE);
          end else if (slave && (gap_cnt == SLAVE_GAP_LAST)) begin
            state     <= S_LOADED;
            shreg     <= next_frame;
            bits_left <= next_len;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // data moves on the falling clock edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_data_out <= 1'b1;
    end else if ((state == S_LOADED) && shift_tick) begin
      serial_data_out <= shreg[0];
    end else if (frame_end && load_now) begin
      serial_data_out <= next_frame[0];
    end else if ((state == S_GAP) && master && shift_tick && buf_valid) begin
      serial_data_out <= next_frame[0];
    end else if (frame_end || (state == S_IDLE) || (state == S_GAP)) begin
      serial_data_out <= 1'b1;
    end else if ((state == S_SHIFT) && shift_tick) begin
      serial_data_out <= shreg[0];
    end
  end

  // master clock: low half then high half of each bit
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_clock_io_out <= 1'b1;
    end else if (master && (state == S_SHIFT) && !frame_end) begin
      serial_clock_io_out <= !shift_tick && (baud_evt ? (div_cnt >= DIV_ONE)
                                                      : (div_cnt[1:0] >= SYNC_CLK_HIGH));
    end else if (master && shift_tick && (state != S_IDLE) && (state != S_SHIFT)) begin
      serial_clock_io_out <= 1'b0;
    end else begin
      serial_clock_io_out <= 1'b1;
    end
  end

  assign serial_clock_io_oe = master;
  assign tx_busy            = (state != S_IDLE);

  // events wait for the next instruction start; set wins
  // buffer empty, transmit complete
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      be_pend         <= 1'b0;
      done_pend       <= 1'b0;
      buf_empty_event <= 1'b0;
      tx_done_event   <= 1'b0;
    end else begin
      buf_empty_event <= instruction_start_strobe && (be_pend || load_now);
      tx_done_event   <= instruction_start_strobe && done_pend;
      if (load_now && !instruction_start_strobe) begin
        be_pend <= 1'b1;
      end else if (instruction_start_strobe) begin
        be_pend <= 1'b0;
      end
      // no done while a byte is queued
      if (frame_end && !buf_valid) begin
        done_pend <= 1'b1;
      end else if (instruction_start_strobe) begin
        done_pend <= 1'b0;
      end
    end
  end

  assign buf_empty_irq = buf_empty_event && tx_control_reg[CTL_BEIE_BIT];
  assign tx_done_irq   = tx_done_event && tx_control_reg[CTL_DONEIE_BIT];
  // baud clocks spent waiting for the first bit
  logic [4:0] wait_cnt;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt <= 5'h00;
    end else if (state != S_LOADED) begin
      wait_cnt <= 5'h00;
    end else if (baud_evt && (wait_cnt != 5'h1F)) begin
      wait_cnt <= 5'(wait_cnt + 1'b1);
    end
  end

  AST_IDLE_HIGH: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state == S_IDLE) && $past(state == S_IDLE) |-> serial_data_out)
    else $error("data not high while idle");
  AST_LOAD_AFTER_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    buf_wr_strobe && buf_wr_ready && (state == S_IDLE) && !buf_valid
    |=> ##1 (state == S_LOADED))
    else $error("write did not load the shifter");
  AST_BE_ALIGN: assert property (@(posedge sys_clk) disable iff (!rst_n)
    buf_empty_event |-> $past(instruction_start_strobe))
    else $error("buffer empty event off the instruction start");
  AST_DONE_ALIGN: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tx_done_event |-> $past(instruction_start_strobe) && $past(done_pend))
    else $error("transmit complete event misaligned");
  AST_START_BIT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !sync_mode && (state == S_LOADED) && shift_tick |=> !serial_data_out)
    else $error("start bit not low");
  AST_UART_WAIT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !sync_mode && !ext_clock_select |-> wait_cnt <= UART_WAIT_MAX)
    else $error("start bit later than sixteen baud clocks");
  AST_MASTER_WAIT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    master |-> wait_cnt <= SYNC_WAIT_MAX)
    else $error("first bit later than four baud clocks");
  AST_GAP_HIGH: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state == S_GAP) ##1 (state == S_GAP) |-> serial_data_out)
    else $error("data not high in reload gap");
  AST_SLAVE_GAP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    slave && (state == S_SHIFT) && frame_end && buf_valid |=> (state == S_GAP) [*2])
    else $error("slave gap shorter than two clocks");
  AST_IRQ_GATE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (buf_empty_irq |-> tx_control_reg[CTL_BEIE_BIT])
    and (tx_done_irq |-> tx_control_reg[CTL_DONEIE_BIT]))
    else $error("interrupt passed a cleared enable");
  AST_MASTER_FALL: assert property (@(posedge sys_clk) disable iff (!rst_n)
    master && (state == S_SHIFT) && $changed(serial_data_out) |-> $fell(serial_clock_io_out))
    else $error("master data changed off the clock fall");

endmodule

// ### bench/sptx_peer.sv
`timescale 1ns/1ns
module sptx_peer (
  // clock and reset
  input  wire logic  sys_clk,
  input  wire logic  rst_n,
  // device pins
  input  wire logic  serial_data_out,
  input  wire logic  serial_clock_io_out,
  input  wire logic  serial_clock_io_oe,
  output logic       serial_clock_io_in,
  // bench side
  input  wire logic  slave_run,
  output logic [63:0] rx_mem,
  output logic [3:0]  n_rx
);
  logic       peer_clk;
  logic       clk_prev;
  logic [1:0] ph;
  logic [2:0] nbit;
  logic [7:0] sh;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph <= 2'h0;
      peer_clk <= 1'b1;
    end else if (slave_run || !peer_clk) begin
      ph <= ph + 2'h1;
      if (ph == 2'h3) begin
        peer_clk <= ~peer_clk;
      end
    end
  end

  // peer_clk drives the pin whenever the device does not
  assign serial_clock_io_in = serial_clock_io_oe ? serial_clock_io_out : peer_clk;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_prev <= 1'b1;
      nbit <= 3'h0;
      sh <= 8'h00;
      rx_mem <= 64'h0;
      n_rx <= 4'h0;
    end else begin
      clk_prev <= serial_clock_io_in;
      if (serial_clock_io_in && !clk_prev) begin
        sh <= {serial_data_out, sh[7:1]};
        nbit <= nbit + 3'h1;
        if (nbit == 3'h7) begin
          rx_mem[8*n_rx[2:0] +: 8] <= {serial_data_out, sh[7:1]};
          n_rx <= n_rx + 4'h1;
        end
      end
    end
  end
endmodule

// ### bench/serial_port_transmitter_bench.sv
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin cmp_count++; if ((ex) !== (got)) begin n_mismatch++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module serial_port_transmitter_bench
  import sptx_pkg::*;
;
  logic              sys_clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              buf_wr_strobe = 1'b0;
  logic [DATA_W-1:0] tx_rx_buffer = 8'h00;
  logic              instruction_start_strobe = 1'b0;
  logic [CTL_W-1:0]  tx_control_reg = 8'h00;
  logic              ext_clock_select = 1'b0;
  logic              baud_tick = 1'b0;
  logic              ext_baud_clock_in = 1'b0;
  logic              slave_run = 1'b0;
  wire               buf_wr_ready, serial_data_out, serial_clock_io_in;
  wire               serial_clock_io_out, serial_clock_io_oe, tx_busy;
  wire               buf_empty_event, tx_done_event, buf_empty_irq, tx_done_irq;
  wire [63:0]        rx_mem;
  wire [3:0]         n_rx;
  int                n_mismatch = 0;
  int                cmp_count = 0;
  int                cyc = 0;
  int                n_empty = 0;
  int                n_done = 0;

  sptx_transmitter #(.BUF_DEPTH(2)) dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .buf_wr_strobe(buf_wr_strobe),
    .tx_rx_buffer(tx_rx_buffer), .buf_wr_ready(buf_wr_ready),
    .instruction_start_strobe(instruction_start_strobe),
    .tx_control_reg(tx_control_reg), .ext_clock_select(ext_clock_select),
    .baud_tick(baud_tick), .ext_baud_clock_in(ext_baud_clock_in),
    .serial_data_out(serial_data_out), .serial_clock_io_in(serial_clock_io_in),
    .serial_clock_io_out(serial_clock_io_out), .serial_clock_io_oe(serial_clock_io_oe),
    .buf_empty_event(buf_empty_event), .tx_done_event(tx_done_event),
    .buf_empty_irq(buf_empty_irq), .tx_done_irq(tx_done_irq), .tx_busy(tx_busy));

  sptx_peer peer (
    .sys_clk(sys_clk), .rst_n(rst_n), .serial_data_out(serial_data_out),
    .serial_clock_io_out(serial_clock_io_out), .serial_clock_io_oe(serial_clock_io_oe),
    .serial_clock_io_in(serial_clock_io_in), .slave_run(slave_run),
    .rx_mem(rx_mem), .n_rx(n_rx));

  always #5 sys_clk = ~sys_clk;

  // baud tick every 4 cycles, external clock same rate
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    #1;
    baud_tick <= (cyc % 4 == 0);
    ext_baud_clock_in <= cyc[1];
    instruction_start_strobe <= (cyc % 3 == 0);
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  always @(posedge sys_clk) begin
    if (buf_empty_event === 1'b1) n_empty++;
    if (tx_done_event === 1'b1) n_done++;
  end

  always @(negedge sys_clk) begin
    if (rst_n) begin
      `CHK("empty_irq", buf_empty_event & tx_control_reg[CTL_BEIE_BIT], buf_empty_irq)
      `CHK("done_irq", tx_done_event & tx_control_reg[CTL_DONEIE_BIT], tx_done_irq)
      if (tx_busy === 1'b0) `CHK("idle_data", 1'b1, serial_data_out)
    end
  end

  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] d);
    cycles(1);
    buf_wr_strobe = 1'b1;
    tx_rx_buffer = d;
    cycles(1);
    buf_wr_strobe = 1'b0;
  endtask

  // a bit lasts 16 ticks of 4 cycles
  task automatic uart_rx(input int n, output logic [11:0] v, output int w);
    w = 0;
    v = 12'h000;
    while (serial_data_out !== 1'b0 && w < 2000) begin
      @(negedge sys_clk);
      w++;
    end
    repeat (32) @(negedge sys_clk);
    for (int i = 0; i < n; i++) begin
      if (i > 0) repeat (64) @(negedge sys_clk);
      v[i] = serial_data_out;
    end
  endtask

  task automatic t_reset;
    `CHK("rst_ready", 1'b1, buf_wr_ready)
    `CHK("rst_busy", 1'b0, tx_busy)
    `CHK("rst_clk", 1'b1, serial_clock_io_out)
  endtask

  task automatic t_uart8;
    logic [11:0] v;
    int w, e0, d0;
    tx_control_reg = 8'hC0;
    e0 = n_empty;
    d0 = n_done;
    wr(8'hA5);
    uart_rx(10, v, w);
    `CHK("u8_frame", {1'b1, 8'hA5, 1'b0}, v[9:0])
    `CHK("u8_start_wait", 1'b1, w <= 68)
    cycles(80);
    `CHK("u8_empty", e0 + 1, n_empty)
    `CHK("u8_done", d0 + 1, n_done)
  endtask

  task automatic t_uart7;
    logic [11:0] v;
    int w, d0;
    tx_control_reg = 8'h7A;
    d0 = n_done;
    wr(8'h35);
    wr(8'h4C);
    uart_rx(11, v, w);
    `CHK("u7_f1", {2'b11, ~^7'h35, 7'h35, 1'b0}, v[10:0])
    uart_rx(11, v, w);
    `CHK("u7_f2", {2'b11, ~^7'h4C, 7'h4C, 1'b0}, v[10:0])
    cycles(80);
    `CHK("u7_done", d0 + 1, n_done)
  endtask

  task automatic t_ext;
    logic [11:0] v;
    int w;
    tx_control_reg = 8'h10;
    ext_clock_select = 1'b1;
    wr(8'hD2);
    uart_rx(11, v, w);
    `CHK("ext_frame", {1'b1, ^8'hD2, 8'hD2, 1'b0}, v[10:0])
    cycles(80);
    ext_clock_select = 1'b0;
  endtask

  task automatic t_master;
    int w, r0;
    tx_control_reg = 8'h01;
    r0 = n_rx;
    wr(8'h3C);
    w = 0;
    while (serial_clock_io_out !== 1'b0 && w < 100) begin
      @(negedge sys_clk);
      w++;
    end
    `CHK("m_first_wait", 1'b1, w <= 20)
    `CHK("m_oe", 1'b1, serial_clock_io_oe)
    `CHK("m_bit0", 1'b0, serial_data_out)
    w = 0;
    while (serial_clock_io_out !== 1'b1 && w < 100) begin
      @(negedge sys_clk);
      w++;
    end
    while (serial_clock_io_out !== 1'b0 && w < 100) begin
      @(negedge sys_clk);
      w++;
    end
    `CHK("m_bit_period", 16, w)
    wr(8'hC3);
    wr(8'h5A);
    `CHK("m_full", 1'b0, buf_wr_ready)
    wr(8'hFF);
    w = 0;
    while (n_rx !== r0 + 3 && w < 1000) begin
      @(negedge sys_clk);
      w++;
    end
    `CHK("m_b0", 8'h3C, rx_mem[8*(r0%8) +: 8])
    `CHK("m_b1", 8'hC3, rx_mem[8*((r0+1)%8) +: 8])
    `CHK("m_b2", 8'h5A, rx_mem[8*((r0+2)%8) +: 8])
    cycles(300);
    `CHK("m_dropped", r0 + 3, n_rx)
    `CHK("m_idle", 1'b0, tx_busy)
  endtask

  task automatic t_slave;
    int w, r0;
    tx_control_reg = 8'h09;
    r0 = n_rx;
    wr(8'h96);
    wr(8'h69);
    cycles(4);
    `CHK("s_oe", 1'b0, serial_clock_io_oe)
    slave_run = 1'b1;
    w = 0;
    while (n_rx !== r0 + 2 && w < 1000) begin
      @(negedge sys_clk);
      w++;
    end
    cycles(1);
    slave_run = 1'b0;
    `CHK("s_b0", 8'h96, rx_mem[8*(r0%8) +: 8])
    `CHK("s_b1", 8'h69, rx_mem[8*((r0+1)%8) +: 8])
    cycles(40);
  endtask

  // stuck slave freed through master mode
  task automatic t_recover;
    tx_control_reg = 8'h09;
    wr(8'h0F);
    slave_run = 1'b1;
    cycles(20);
    slave_run = 1'b0;
    cycles(8);
    `CHK("r_stuck", 1'b1, tx_busy)
    tx_control_reg = 8'h01;
    wr(8'hF0);
    cycles(400);
    `CHK("r_freed", 1'b0, tx_busy)
    `CHK("r_ready", 1'b1, buf_wr_ready)
    tx_control_reg = 8'h09;
    cycles(1);
    `CHK("r_slave_oe", 1'b0, serial_clock_io_oe)
  endtask

  task automatic give_verdict;
    if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    cycles(20);
    rst_n = 1'b1;
    t_reset();
    t_uart8();
    t_uart7();
    t_ext();
    t_master();
    t_slave();
    t_recover();
    give_verdict();
  end
endmodule
